/* core/pms_ms_timer.sv */
`timescale 1ns/100ps
`default_nettype none
module pms_ms_timer #(
   parameter int CYC_PER_MS = pms_pkg::CYC_PER_MS
) (
   // Clock, reset and enable.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // Control.
   input wire logic start,
   input wire logic [pms_pkg::MS_W-1:0] ms_value,
   // Status.
   output logic expired
);
   import pms_pkg::*;
   logic [31:0] pre;
   logic [MS_W-1:0] ms_left;
   logic running;
   wire pre_wrap = pre == 32'(CYC_PER_MS - 1);

   // A start rearms the timer and clears any stale expiry at once.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         pre <= 32'h00000000;
         ms_left <= 17'h00000;
         running <= 1'b0;
         expired <= 1'b0;
      end
      else if (ce)
      begin
         if (start)
         begin
            pre <= 32'h00000000;
            ms_left <= ms_value;
            running <= 1'b1;
            expired <= 1'b0;
         end
         else if (running)
         begin
            if (ms_left == 17'h00000)
            begin
               running <= 1'b0;
               expired <= 1'b1;
            end
            else
            begin
               pre <= pre_wrap ? 32'h00000000 : pre + 32'h00000001;
               if (pre_wrap)
                  ms_left <= ms_left - 17'h00001;
            end
         end
      end
   end
endmodule
`default_nettype wire

/* core/pms_pkg.sv */
`default_nettype none
package pms_pkg;
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned MS_NS = 1000000;
   localparam int unsigned CYC_PER_MS = (MS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int POLL_MAX = 15;
   localparam int CMP_CHARS = 23;
   localparam int NSTATION = 32;
   localparam int NTABLE = 16;
   localparam int TBL_BYTES = 32;
   localparam int NPAIR = 6;
   localparam int CNT_W = 17;
   localparam int MS_W = 17;
   localparam logic [CNT_W-1:0] CNT_MAX = 17'h1869F;
   localparam logic [11:0] OFS_CTRL = 12'h000;
   localparam logic [11:0] OFS_STATUS = 12'h004;
   localparam logic [11:0] OFS_CONFIG = 12'h008;
   localparam logic [11:0] OFS_RESP_DLY = 12'h00C;
   localparam logic [11:0] OFS_TIMEOUT = 12'h010;
   localparam logic [11:0] OFS_REPEAT = 12'h014;
   localparam logic [11:0] OFS_REPS = 12'h018;
   localparam logic [11:0] OFS_ERR_ENTRY = 12'h030;
   localparam logic [11:0] OFS_TMO_ENTRY = 12'h034;
   localparam logic [11:0] OFS_POLL = 12'h040;
   localparam logic [11:0] OFS_PAIR = 12'h080;
   localparam logic [11:0] OFS_SLOT_ADDR = 12'h100;
   localparam logic [11:0] OFS_SLOT_LEN = 12'h180;
   localparam logic [11:0] OFS_TBL_LEN = 12'h200;
   localparam logic [11:0] OFS_COUNT = 12'h400;
   localparam logic [11:0] OFS_TBL_MEM = 12'h800;
   localparam int CTRL_RUN = 0;
   localparam int CTRL_STOP = 1;
   localparam int CTRL_CLR = 2;
   localparam int ENTRY_WILD = 4;
   localparam int PAIR_B_LSB = 8;
   localparam int PAIR_B_WILD = 12;
   localparam logic [MS_W-1:0] RESP_DLY_RST = 17'h00000;
   localparam logic [MS_W-1:0] TIMEOUT_RST = 17'h00000;
   localparam logic [CNT_W-1:0] REPEAT_RST = 17'h00000;
   typedef enum logic [1:0] {PMS_ASYNC = 2'h0, PMS_SYNC = 2'h1, PMS_HDLC = 2'h2} pms_proto_t;
   typedef enum logic [2:0] {
      PMS_IDLE = 3'h0, PMS_FIND = 3'h1, PMS_SEND = 3'h3, PMS_WAIT = 3'h2,
      PMS_CMP = 3'h6, PMS_DELAY = 3'h7
   } pms_state_t;
   typedef enum logic [1:0] {PMS_ACT_NEXT = 2'h0, PMS_ACT_REPLY_NEXT = 2'h1,
      PMS_ACT_REPLY_WAIT = 2'h2} pms_act_t;
endpackage
`default_nettype wire

/* core/pms_sequencer.sv */
`timescale 1ns/100ps
`default_nettype none
module pms_sequencer #(
   parameter int CYC_PER_MS = pms_pkg::CYC_PER_MS
) (
   // Clock, reset and enable.
   input wire logic pclk,
   input wire logic presetn,
   input wire logic ce,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Transmit byte stream.
   output logic [7:0] tx_data,
   output logic tx_valid,
   input wire logic tx_ready,
   // Receive byte stream with end-of-frame status.
   input wire logic [7:0] rx_data,
   input wire logic rx_valid,
   input wire logic rx_end,
   input wire logic rx_parity_err,
   input wire logic rx_framing_err,
   input wire logic rx_block_check_err,
   // Control lines.
   output logic rts,
   output logic dtr,
   output logic busy
);
   import pms_pkg::*;
   pms_state_t state;
   pms_act_t act;
   pms_proto_t proto;
   logic [3:0] poll_len;
   logic [MS_W-1:0] resp_dly, timeout_ms;
   logic [CNT_W-1:0] repeat_cfg, reps;
   logic [7:0] poll_chr [POLL_MAX];
   logic [POLL_MAX-1:0] poll_wild;
   logic [31:0] slot_addr [NSTATION];
   logic [2:0] slot_len [NSTATION];
   logic [4:0] table_len [NTABLE];
   logic [7:0] table_mem [NTABLE][TBL_BYTES];
   logic [3:0] pair_a [NPAIR], pair_b [NPAIR];
   logic [NPAIR-1:0] pair_a_wild, pair_b_wild;
   logic [3:0] err_tbl, timeout_reply_entry;
   logic err_wild, tmo_wild;
   logic [CNT_W-1:0] cnt_ok [NSTATION], mismatch_reply_count [NSTATION];
   logic [CNT_W-1:0] cnt_err [NSTATION], cnt_tmo [NSTATION];
   logic [7:0] rx_buf [CMP_CHARS];
   logic [4:0] rx_len, station_number, tx_idx;
   logic [5:0] scan;
   logic [2:0] pair_idx;
   logic [1:0] wild_k;
   logic [3:0] src_tbl, reply_tbl;
   logic src_poll, wait_after, step;
   logic dly_expired, tmo_expired, cmp_eq;

   // Bus decode.
   wire wr_en = ce && psel && penable && pwrite;
   wire rd_setup = ce && psel && !penable;
   wire hit_ctrl = paddr == OFS_CTRL;
   wire hit_status = paddr == OFS_STATUS;
   wire hit_cfg = paddr == OFS_CONFIG;
   wire hit_dly = paddr == OFS_RESP_DLY;
   wire hit_tmo = paddr == OFS_TIMEOUT;
   wire hit_rep = paddr == OFS_REPEAT;
   wire hit_reps = paddr == OFS_REPS;
   wire hit_erre = paddr == OFS_ERR_ENTRY;
   wire hit_tmoe = paddr == OFS_TMO_ENTRY;
   wire [3:0] a_poll = paddr[5:2];
   wire hit_poll = paddr[11:6] == OFS_POLL[11:6] && a_poll < 4'(POLL_MAX);
   wire [2:0] a_pair = paddr[4:2];
   wire hit_pair = paddr[11:5] == OFS_PAIR[11:5] && a_pair < 3'(NPAIR);
   wire [4:0] a_slot = paddr[6:2];
   wire hit_saddr = paddr[11:7] == OFS_SLOT_ADDR[11:7];
   wire hit_slen = paddr[11:7] == OFS_SLOT_LEN[11:7];
   wire [3:0] a_tlen = paddr[5:2];
   wire hit_tlen = paddr[11:6] == OFS_TBL_LEN[11:6];
   wire [4:0] a_cst = paddr[8:4];
   wire hit_cnt = paddr[11:9] == OFS_COUNT[11:9];
   wire [3:0] a_tbl = paddr[10:7];
   wire [4:0] a_tbyte = paddr[6:2];
   wire hit_tmem = paddr[11] == OFS_TBL_MEM[11];
   wire hit_any = hit_ctrl | hit_status | hit_cfg | hit_dly | hit_tmo | hit_rep | hit_reps
      | hit_erre | hit_tmoe | hit_poll | hit_pair | hit_saddr | hit_slen | hit_tlen
      | hit_cnt | hit_tmem;
   wire run_cmd = wr_en && hit_ctrl && pwdata[CTRL_RUN];
   wire stop_cmd = wr_en && hit_ctrl && pwdata[CTRL_STOP];
   wire clr_cmd = wr_en && hit_ctrl && pwdata[CTRL_CLR];
   wire [CNT_W-1:0] cnt_sel = paddr[3:2] == 2'h0 ? cnt_ok[a_cst]
      : paddr[3:2] == 2'h1 ? mismatch_reply_count[a_cst]
      : paddr[3:2] == 2'h2 ? cnt_err[a_cst] : cnt_tmo[a_cst];
   wire [31:0] rd_word = hit_status ? {19'h00000, station_number, 7'h00, busy}
      : hit_cfg ? {24'h000000, poll_len, 2'h0, proto}
      : hit_dly ? {15'h0000, resp_dly} : hit_tmo ? {15'h0000, timeout_ms}
      : hit_rep ? {15'h0000, repeat_cfg} : hit_reps ? {15'h0000, reps}
      : hit_erre ? {27'h0000000, err_wild, err_tbl}
      : hit_tmoe ? {27'h0000000, tmo_wild, timeout_reply_entry}
      : hit_poll ? {23'h000000, poll_wild[a_poll], poll_chr[a_poll]}
      : hit_pair ? {19'h00000, pair_b_wild[a_pair], pair_b[a_pair], 3'h0,
         pair_a_wild[a_pair], pair_a[a_pair]}
      : hit_saddr ? slot_addr[a_slot] : hit_slen ? {29'h00000000, slot_len[a_slot]}
      : hit_tlen ? {27'h0000000, table_len[a_tlen]}
      : hit_cnt ? {15'h0000, cnt_sel}
      : hit_tmem ? {24'h000000, table_mem[a_tbl][a_tbyte]} : 32'h00000000;
   assign pready = ce;
   assign pslverr = psel && penable && !hit_any;

   // Link side selection.
   // Protocol error mask
   wire rx_comm_err = rx_block_check_err | (proto != PMS_HDLC && rx_parity_err)
      | (proto == PMS_ASYNC && rx_framing_err);
   wire [2:0] cur_alen = slot_len[station_number];
   wire [4:0] tx_len = src_poll ? {1'b0, poll_len} : table_len[src_tbl];
   wire [3:0] pidx = tx_idx[3:0];
   wire [1:0] ab_sel = 2'(cur_alen - 3'h1 - {1'b0, wild_k});
   wire [7:0] addr_byte = slot_addr[station_number][{ab_sel, 3'h0} +: 8];
   wire cur_wild = src_poll && pidx < 4'(POLL_MAX) && poll_wild[pidx];
   wire [7:0] cur_byte = !src_poll ? table_mem[src_tbl][tx_idx]
      : cur_wild ? addr_byte : poll_chr[pidx];
   wire [1:0] next_wild_k = 3'({1'b0, wild_k} + 3'h1) == cur_alen ? 2'h0 : wild_k + 2'h1;
   wire send_done = state == PMS_SEND && !tx_valid && tx_idx >= tx_len;
   wire tmo_on = timeout_ms != 17'h00000;
   wire tmo_start = ce && send_done && wait_after;
   wire dly_start = ce && state == PMS_WAIT && rx_end;
   wire rx_take = ce && state == PMS_WAIT && rx_valid && rx_len < 5'(CMP_CHARS);
   wire [3:0] cmp_tbl = pair_a[pair_idx];
   wire [4:0] tbl_eff = table_len[cmp_tbl] > 5'(CMP_CHARS) ? 5'(CMP_CHARS)
      : table_len[cmp_tbl];
   wire pair_hit = !pair_a_wild[pair_idx] && cmp_eq;
   wire last_pair = pair_idx == 3'(NPAIR - 1);
   wire last_slot = station_number == 5'(NSTATION - 1);
   wire last_rep = repeat_cfg != 17'h00000 && reps + 17'h00001 == repeat_cfg;

   always_comb
   begin
      cmp_eq = rx_len == tbl_eff;
      for (int i = 0; i < CMP_CHARS; i++)
         if (5'(i) < rx_len && rx_buf[i] != table_mem[cmp_tbl][i])
            cmp_eq = 1'b0;
   end

   function automatic logic [CNT_W-1:0] sat_inc(input logic [CNT_W-1:0] v);
      return v == CNT_MAX ? v : v + 17'h00001;
   endfunction

   pms_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_dly (
      .pclk(pclk), .presetn(presetn), .ce(ce),
      .start(dly_start), .ms_value(resp_dly), .expired(dly_expired));
   pms_ms_timer #(.CYC_PER_MS(CYC_PER_MS)) u_tmo (
      .pclk(pclk), .presetn(presetn), .ce(ce),
      .start(tmo_start), .ms_value(timeout_ms), .expired(tmo_expired));

   // Storage without reset: message text, addresses, tables, reply capture.
   always_ff @(posedge pclk)
   begin
      if (wr_en && hit_poll)
      begin
         poll_chr[a_poll] <= pwdata[7:0];
      end
      if (wr_en && hit_saddr)
         slot_addr[a_slot] <= pwdata;
      if (wr_en && hit_tmem)
         table_mem[a_tbl][a_tbyte] <= pwdata[7:0];
      if (rx_take)
         rx_buf[rx_len] <= rx_data;
   end

   // Configuration registers.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         proto <= PMS_ASYNC;
         poll_len <= 4'h0;
         resp_dly <= RESP_DLY_RST;
         timeout_ms <= TIMEOUT_RST;
         repeat_cfg <= REPEAT_RST;
         poll_wild <= '0;
         err_tbl <= 4'h0;
         err_wild <= 1'b1;
         timeout_reply_entry <= 4'h0;
         tmo_wild <= 1'b1;
         pair_a_wild <= '1;
         pair_b_wild <= '1;
         for (int i = 0; i < NPAIR; i++)
         begin
            pair_a[i] <= 4'h0;
            pair_b[i] <= 4'h0;
         end
         for (int i = 0; i < NSTATION; i++)
            slot_len[i] <= 3'h0;
         for (int i = 0; i < NTABLE; i++)
            table_len[i] <= 5'h00;
      end
      else if (wr_en)
      begin
         if (hit_cfg)
         begin
            proto <= pms_proto_t'(pwdata[1:0]);
            poll_len <= pwdata[7:4] > 4'(POLL_MAX) ? 4'(POLL_MAX) : pwdata[7:4];
         end
         if (hit_dly)
            resp_dly <= pwdata[MS_W-1:0];
         if (hit_tmo)
            timeout_ms <= pwdata[MS_W-1:0];
         if (hit_rep)
            repeat_cfg <= pwdata[CNT_W-1:0];
         if (hit_erre)
         begin
            err_tbl <= pwdata[3:0];
            err_wild <= pwdata[ENTRY_WILD];
         end
         if (hit_tmoe)
         begin
            timeout_reply_entry <= pwdata[3:0];
            tmo_wild <= pwdata[ENTRY_WILD];
         end
         if (hit_poll)
            poll_wild[a_poll] <= pwdata[8];
         if (hit_pair)
         begin
            pair_a[a_pair] <= pwdata[3:0];
            pair_a_wild[a_pair] <= pwdata[ENTRY_WILD];
            pair_b[a_pair] <= pwdata[PAIR_B_LSB +: 4];
            pair_b_wild[a_pair] <= pwdata[PAIR_B_WILD];
         end
         if (hit_slen)
            slot_len[a_slot] <= pwdata[2:0] > 3'h4 ? 3'h4 : pwdata[2:0];
         if (hit_tlen)
            table_len[a_tlen] <= pwdata[4:0];
      end
   end

   // Read data is captured in the setup phase, so it comes from flip-flops.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (rd_setup)
         prdata <= rd_word;
   end

   assign dtr = rts;
   assign busy = state != PMS_IDLE;

   // Polling sequence and per-station counters.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         state <= PMS_IDLE;
         act <= PMS_ACT_NEXT;
         rts <= 1'b0;
         tx_data <= 8'h00;
         tx_valid <= 1'b0;
         tx_idx <= 5'h00;
         wild_k <= 2'h0;
         src_poll <= 1'b1;
         src_tbl <= 4'h0;
         reply_tbl <= 4'h0;
         wait_after <= 1'b0;
         step <= 1'b0;
         station_number <= 5'h00;
         scan <= 6'h00;
         reps <= 17'h00000;
         rx_len <= 5'h00;
         pair_idx <= 3'h0;
         for (int i = 0; i < NSTATION; i++)
         begin
            cnt_ok[i] <= 17'h00000;
            mismatch_reply_count[i] <= 17'h00000;
            cnt_err[i] <= 17'h00000;
            cnt_tmo[i] <= 17'h00000;
         end
      end
      else if (ce)
      begin
         if (clr_cmd)
            for (int i = 0; i < NSTATION; i++)
            begin
               cnt_ok[i] <= 17'h00000;
               mismatch_reply_count[i] <= 17'h00000;
               cnt_err[i] <= 17'h00000;
               cnt_tmo[i] <= 17'h00000;
            end
         if (rx_take)
            rx_len <= rx_len + 5'h01;
         if (stop_cmd)
         begin
            state <= PMS_IDLE;
            rts <= 1'b0;
            tx_valid <= 1'b0;
         end
         else
         begin
            unique case (state)
               PMS_IDLE:
               if (run_cmd)
               begin
                  rts <= 1'b1;
                  station_number <= 5'h00;
                  step <= 1'b0;
                  scan <= 6'h00;
                  reps <= 17'h00000;
                  state <= PMS_FIND;
               end
               PMS_FIND:
               if (step)
               begin
                  step <= 1'b0;
                  station_number <= station_number + 5'h01;
                  if (last_slot)
                  begin
                     reps <= reps + 17'h00001;
                     if (last_rep)
                     begin
                        state <= PMS_IDLE;
                        rts <= 1'b0;
                     end
                  end
               end
               else if (cur_alen != 3'h0)
               begin
                  scan <= 6'h00;
                  src_poll <= 1'b1;
                  tx_idx <= 5'h00;
                  wild_k <= 2'h0;
                  wait_after <= 1'b1;
                  state <= PMS_SEND;
               end
               else if (scan == 6'(NSTATION - 1))
               begin
                  state <= PMS_IDLE;
                  rts <= 1'b0;
               end
               else
               begin
                  scan <= scan + 6'h01;
                  step <= 1'b1;
               end
               PMS_SEND:
               if (tx_valid)
               begin
                  if (tx_ready)
                     tx_valid <= 1'b0;
               end
               else if (tx_idx < tx_len)
               begin
                  tx_data <= cur_byte;
                  tx_valid <= 1'b1;
                  tx_idx <= tx_idx + 5'h01;
                  if (cur_wild)
                     wild_k <= next_wild_k;
               end
               else if (wait_after)
               begin
                  rx_len <= 5'h00;
                  state <= PMS_WAIT;
               end
               else
               begin
                  step <= 1'b1;
                  state <= PMS_FIND;
               end
               PMS_WAIT:
               if (rx_end)
               begin
                  if (rx_comm_err)
                  begin
                     cnt_err[station_number] <= sat_inc(cnt_err[station_number]);
                     reply_tbl <= err_tbl;
                     act <= err_wild ? PMS_ACT_NEXT : PMS_ACT_REPLY_WAIT;
                     state <= PMS_DELAY;
                  end
                  else
                  begin
                     pair_idx <= 3'h0;
                     state <= PMS_CMP;
                  end
               end
               else if (tmo_on && tmo_expired)
               begin
                  cnt_tmo[station_number] <= sat_inc(cnt_tmo[station_number]);
                  if (tmo_wild)
                  begin
                     step <= 1'b1;
                     state <= PMS_FIND;
                  end
                  else
                  begin
                     src_poll <= 1'b0;
                     src_tbl <= timeout_reply_entry;
                     tx_idx <= 5'h00;
                     wait_after <= 1'b1;
                     state <= PMS_SEND;
                  end
               end
               PMS_CMP:
               if (pair_hit)
               begin
                  cnt_ok[station_number] <= sat_inc(cnt_ok[station_number]);
                  reply_tbl <= pair_b[pair_idx];
                  act <= pair_b_wild[pair_idx] ? PMS_ACT_NEXT : PMS_ACT_REPLY_NEXT;
                  state <= PMS_DELAY;
               end
               else if (last_pair)
               begin
                  mismatch_reply_count[station_number] <=
                     sat_inc(mismatch_reply_count[station_number]);
                  act <= PMS_ACT_NEXT;
                  state <= PMS_DELAY;
               end
               else
                  pair_idx <= pair_idx + 3'h1;
               PMS_DELAY:
               if (dly_expired)
               begin
                  if (act == PMS_ACT_NEXT)
                  begin
                     step <= 1'b1;
                     state <= PMS_FIND;
                  end
                  else
                  begin
                     src_poll <= 1'b0;
                     src_tbl <= reply_tbl;
                     tx_idx <= 5'h00;
                     wait_after <= act == PMS_ACT_REPLY_WAIT;
                     state <= PMS_SEND;
                  end
               end
               default:
               begin
                  state <= PMS_IDLE;
                  rts <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule
`default_nettype wire

/* tb/pms_sequencer_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
module pms_sequencer_asserts (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Watched ports.
   input wire logic ce,
   input wire logic psel,
   input wire logic penable,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic tx_valid,
   input wire logic tx_ready,
   input wire logic [7:0] tx_data,
   input wire logic rts,
   input wire logic dtr,
   input wire logic busy
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   a_ready_is_ce:
      assert property (pready == ce) else $error("pready differs from ce");
   a_slverr_access:
      assert property (pslverr |-> psel && penable) else $error("pslverr outside access");
   a_tx_hold:
      assert property (tx_valid && !tx_ready && busy
         |=> !busy || (tx_valid && $stable(tx_data)))
         else $error("tx byte dropped before accept");
   a_tx_gap:
      assert property (tx_valid && tx_ready |=> !tx_valid) else $error("no gap after tx byte");
   a_lines_pair:
      assert property (rts == dtr) else $error("rts and dtr differ");
   a_tx_in_run:
      assert property (tx_valid |-> rts && dtr) else $error("tx while control lines low");
   a_run_busy:
      assert property (rts |-> busy) else $error("control lines high while idle");
   a_idle_silent:
      assert property (!busy |-> !tx_valid) else $error("tx while idle");
   c_tx_byte: cover property (tx_valid && tx_ready);
   c_slverr: cover property (pslverr);
   c_run_end: cover property ($fell(busy));
endmodule
`default_nettype wire

/* tb/pms_sequencer_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module pms_sequencer_tb;
   import pms_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h00000000;
   wire logic [31:0] prdata;
   wire logic pready, pslverr, tx_valid, tx_ready, rx_valid, rx_end, rts, dtr, busy;
   wire logic [7:0] tx_data, rx_data;
   logic [31:0] rd;
   logic err;
   logic [7:0] sent[$];
   int mismatches = 0;
   int checks_done = 0;
   int cyc = 0;
   always #12.5 pclk = ~pclk;
   pms_sequencer #(.CYC_PER_MS(4)) u_dut (.pclk(pclk), .presetn(presetn), .ce(1'b1),
      .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
      .rx_end(rx_end), .rx_parity_err(1'b0), .rx_framing_err(1'b0),
      .rx_block_check_err(1'b0), .rts(rts), .dtr(dtr), .busy(busy));
   pms_slave_model u_slave (.pclk(pclk), .presetn(presetn), .tx_valid(tx_valid),
      .tx_data(tx_data), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
      .rx_end(rx_end));
   always @(posedge pclk)
   begin
      if (tx_valid === 1'b1 && tx_ready === 1'b1)
         sent.push_back(tx_data);
      cyc++;
      if (cyc == 20000)
      begin
         mismatches++;
         conclude();
      end
   end
   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      checks_done++;
      if (got !== exp)
      begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", name, exp, got);
      end
   endtask
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1)
         @(posedge pclk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic rd_chk(input logic [11:0] a, input logic [31:0] exp);
      apb(1'b0, a, 32'h00000000);
      chk($sformatf("reg %h", a), exp, rd);
   endtask
   task automatic t_regs();
      rd_chk(12'h030, 32'h00000010);
      rd_chk(12'h034, 32'h00000010);
      rd_chk(12'h014, 32'h00000000);
      apb(1'b0, 12'h020, 32'h00000000);
      chk("pslverr", 32'h1, {31'h0, err});
   endtask
   task automatic t_poll();
      logic [11:0] wa[12] = '{12'h008, 12'h040, 12'h044, 12'h10C, 12'h18C, 12'h200,
         12'h204, 12'h800, 12'h880, 12'h080, 12'h014, 12'h000};
      logic [31:0] wd[12] = '{32'h20, 32'h50, 32'h100, 32'hABABABAB, 32'h1, 32'h1,
         32'h1, 32'h11, 32'h22, 32'h100, 32'h1, 32'h1};
      int n;
      n = 0;
      foreach (wa[i])
         apb(1'b1, wa[i], wd[i]);
      while (busy !== 1'b0 || sent.size() < 3)
      begin
         @(posedge pclk);
         n++;
         if (sent.size() == 1 && n < 1000)
            chk("rts", 32'h1, {31'h0, rts});
      end
      chk("tx count", 32'h00000003, sent.size());
      chk("tx0", 32'h50, sent[0]);
      chk("tx1", 32'hAB, sent[1]);
      chk("tx2", 32'h22, sent[2]);
      rd_chk(12'h430, 32'h00000001);
      rd_chk(12'h434, 32'h00000000);
      rd_chk(12'h438, 32'h00000000);
      rd_chk(12'h43C, 32'h00000000);
      rd_chk(12'h018, 32'h00000001);
   endtask
   // A silent slave: each timeout sends table 0 and waits again on the same slave.
   task automatic t_tmo();
      sent.delete();
      apb(1'b1, 12'h10C, 32'h000000CD);
      apb(1'b1, 12'h010, 32'h00000001);
      apb(1'b1, 12'h034, 32'h00000000);
      apb(1'b1, 12'h000, 32'h00000001);
      while (sent.size() < 4)
         @(posedge pclk);
      apb(1'b1, 12'h000, 32'h00000002);
      chk("rts after stop", 32'h0, {31'h0, rts});
      chk("busy after stop", 32'h0, {31'h0, busy});
      chk("tmo tx0", 32'h50, sent[0]);
      chk("tmo tx1", 32'hCD, sent[1]);
      chk("tmo tx2", 32'h11, sent[2]);
      chk("tmo tx3", 32'h11, sent[3]);
      rd_chk(12'h43C, 32'h00000002);
      rd_chk(12'h430, 32'h00000001);
   endtask
   task automatic conclude();
      if (mismatches == 0 && checks_done > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   initial
   begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_regs();
      t_poll();
      t_tmo();
      conclude();
   end
endmodule
bind pms_sequencer pms_sequencer_asserts u_chk (.pclk(pclk), .presetn(presetn), .ce(ce),
   .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .tx_valid(tx_valid),
   .tx_ready(tx_ready), .tx_data(tx_data), .rts(rts), .dtr(dtr), .busy(busy));
`default_nettype wire

/* tb/pms_slave_model.sv */
`timescale 1ns/100ps
`default_nettype none
module pms_slave_model (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Link.
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready,
   output logic [7:0] rx_data,
   output logic rx_valid,
   output logic rx_end
);
   logic [3:0] wait_cnt;
   // Accepts each byte one cycle late and answers only the byte AB, with the single byte 11.
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         tx_ready <= 1'b0;
         rx_valid <= 1'b0;
         rx_end <= 1'b0;
         rx_data <= 8'h00;
         wait_cnt <= 4'h0;
      end
      else
      begin
         tx_ready <= tx_valid && !tx_ready;
         rx_valid <= wait_cnt == 4'h1;
         rx_end <= wait_cnt == 4'h1;
         rx_data <= (wait_cnt == 4'h1) ? 8'h11 : ~rx_data;
         if (tx_valid && tx_ready && tx_data == 8'hAB)
            wait_cnt <= 4'h5;
         else if (wait_cnt != 4'h0)
            wait_cnt <= wait_cnt - 4'h1;
      end
   end
endmodule
`default_nettype wire
